//--- design/phy_ctrl_pkg.sv
// constants for the per-port basic control word, lower half
// assumes a 100 MHz core clock and 100 Mb/s bit rate on the MII side
package phy_ctrl_pkg;
  localparam int REG_ADDR_W = 5;
  localparam int REG_DATA_W = 16;
  localparam logic [REG_ADDR_W-1:0] PORT_BASIC_CONTROL_OFFSET = 5'h00;
  localparam logic [REG_DATA_W-1:0] PORT_BASIC_CONTROL_RESET = 16'h0000;

  localparam int POWER_DOWN_BIT = 11;
  localparam int ISOLATE_BIT = 10;
  localparam int RESTART_AN_BIT = 9;
  localparam int DUPLEX_BIT = 8;
  localparam int COL_TEST_BIT = 7;
  localparam int RESERVED_HI_BIT = 6;
  localparam int RESERVED_LO_BIT = 0;

  // bit times at 100 Mb/s
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_TIME_NS = 10;
  localparam int COL_ON_MAX_BITS = 512;
  localparam int COL_OFF_MAX_BITS = 4;
  // longest times round down
  localparam int COL_ON_MAX_CYCLES =
    (COL_ON_MAX_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
  localparam int COL_OFF_MAX_CYCLES =
    (COL_OFF_MAX_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;

  // synchroniser settle count before the strap is trusted;
  // stage three first holds the strap at the third edge after release
  localparam int STRAP_SETTLE_W = 3;
  localparam logic [STRAP_SETTLE_W-1:0] STRAP_SETTLE_DONE = 3'h4;
endpackage : phy_ctrl_pkg

//--- design/phy_basic_control_lower_bits.sv
// lower half of the per-port basic control word of a 10/100 phy port
// assumes register access by word strobes from the management frame logic,
// and tx enable from the mac already in the core clock domain
`timescale 1ns/1ps
module phy_basic_control_lower_bits (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [phy_ctrl_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic [phy_ctrl_pkg::REG_DATA_W-1:0] regWriteData,
  output logic [phy_ctrl_pkg::REG_DATA_W-1:0] regReadData,
  input wire logic power_down_input_pin_n,
  input wire logic duplexStrap,
  input wire logic anEnable,
  input wire logic anStarted,
  input wire logic anFullDuplex,
  input wire logic txEn,
  output logic portPowerDown,
  output logic portIsolate,
  output logic anRestartReq,
  output logic fullDuplex,
  output logic col
);
  import phy_ctrl_pkg::*;

  // pin synchronisers: stage 1 feeds stage 2 only
  logic [2:0] pdPinSync;
  logic [2:0] next_pdPinSync;
  logic [2:0] strapSync;
  logic [2:0] next_strapSync;
  logic pdPinLow;
  logic next_pdPinLow;

  // control bits
  logic powerDownBit;
  logic next_powerDownBit;
  logic isolateBit;
  logic next_isolateBit;
  logic restartBit;
  logic next_restartBit;
  logic duplexBit;
  logic next_duplexBit;
  logic colTestBit;
  logic next_colTestBit;
  logic [STRAP_SETTLE_W-1:0] strapSettle;
  logic [STRAP_SETTLE_W-1:0] next_strapSettle;

  // registered outputs
  logic [REG_DATA_W-1:0] next_regReadData;
  logic next_portPowerDown;
  logic next_portIsolate;
  logic next_anRestartReq;
  logic next_fullDuplex;
  logic next_col;

  logic ctrlWrite;
  logic pdEffective;

  function automatic logic [REG_DATA_W-1:0] pack_word(
    input logic pd,
    input logic iso,
    input logic rst,
    input logic dup,
    input logic ct
  );
    logic [REG_DATA_W-1:0] w;
    w = '0;
    w[POWER_DOWN_BIT] = pd;
    w[ISOLATE_BIT] = iso;
    w[RESTART_AN_BIT] = rst;
    w[DUPLEX_BIT] = dup;
    w[COL_TEST_BIT] = ct;
    return w;
  endfunction : pack_word

  function automatic logic is_ctrl_addr(
    input logic [REG_ADDR_W-1:0] a
  );
    return a == PORT_BASIC_CONTROL_OFFSET;
  endfunction : is_ctrl_addr

  // pin synchronisers and strap settle counter
  always_comb begin
    next_pdPinSync = {pdPinSync[1:0], power_down_input_pin_n};
    next_strapSync = {strapSync[1:0], duplexStrap};
    // a change counts once stages two and three agree
    next_pdPinLow = pdPinLow;
    if (pdPinSync[1] == pdPinSync[2]) begin
      next_pdPinLow = ~pdPinSync[2];
    end

    next_strapSettle = strapSettle;
    if (strapSettle != STRAP_SETTLE_DONE) begin
      next_strapSettle = strapSettle + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pdPinSync <= 3'h7;
      strapSync <= 3'h0;
      pdPinLow <= 1'b0;
      strapSettle <= '0;
    end else if (clkEn) begin
      pdPinSync <= next_pdPinSync;
      strapSync <= next_strapSync;
      pdPinLow <= next_pdPinLow;
      strapSettle <= next_strapSettle;
    end
  end

  // control bits
  always_comb begin
    ctrlWrite = regWrite && is_ctrl_addr(regAddr);

    next_duplexBit = duplexBit;
    next_powerDownBit = powerDownBit;
    next_isolateBit = isolateBit;
    next_colTestBit = colTestBit;
    next_restartBit = restartBit;

    // negotiation has begun: self clear
    if (anStarted) begin
      next_restartBit = 1'b0;
    end

    if (ctrlWrite) begin
      next_powerDownBit = regWriteData[POWER_DOWN_BIT];
      next_isolateBit = regWriteData[ISOLATE_BIT];
      next_duplexBit = regWriteData[DUPLEX_BIT];
      next_colTestBit = regWriteData[COL_TEST_BIT];
      // writing zero leaves a pending restart alone
      if (regWriteData[RESTART_AN_BIT] && anEnable) begin
        next_restartBit = 1'b1;
      end
      // bits 6:0 have no storage, so writes there vanish
    end

    // strap lands last so a write during settling cannot beat it;
    // taken only once stage three holds a real sample, not reset fill
    if (strapSettle == STRAP_SETTLE_DONE - 1'b1) begin
      next_duplexBit = strapSync[2];
    end

    // pin low wins over a software clear in the same cycle
    if (pdPinLow) begin
      next_powerDownBit = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      powerDownBit <= PORT_BASIC_CONTROL_RESET[POWER_DOWN_BIT];
      isolateBit <= PORT_BASIC_CONTROL_RESET[ISOLATE_BIT];
      restartBit <= PORT_BASIC_CONTROL_RESET[RESTART_AN_BIT];
      duplexBit <= PORT_BASIC_CONTROL_RESET[DUPLEX_BIT];
      colTestBit <= PORT_BASIC_CONTROL_RESET[COL_TEST_BIT];
    end else if (clkEn) begin
      powerDownBit <= next_powerDownBit;
      isolateBit <= next_isolateBit;
      restartBit <= next_restartBit;
      duplexBit <= next_duplexBit;
      colTestBit <= next_colTestBit;
    end
  end

  // registered outputs
  always_comb begin
    pdEffective = powerDownBit | pdPinLow;

    next_regReadData = '0;
    if (is_ctrl_addr(regAddr)) begin
      next_regReadData = pack_word(powerDownBit, isolateBit, restartBit,
                                   duplexBit, colTestBit);
    end

    next_portPowerDown = pdEffective;
    next_portIsolate = isolateBit;
    next_anRestartReq = restartBit & anEnable & ~pdEffective;
    // port mode ignores the bit while negotiation runs
    next_fullDuplex = anEnable ? anFullDuplex : duplexBit;
    // one cycle each way, far inside both bounds; quiet when cut off
    next_col = colTestBit & txEn & ~isolateBit & ~pdEffective;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regReadData <= '0;
      portPowerDown <= 1'b0;
      portIsolate <= 1'b0;
      anRestartReq <= 1'b0;
      fullDuplex <= 1'b0;
      col <= 1'b0;
    end else if (clkEn) begin
      regReadData <= next_regReadData;
      portPowerDown <= next_portPowerDown;
      portIsolate <= next_portIsolate;
      anRestartReq <= next_anRestartReq;
      fullDuplex <= next_fullDuplex;
      col <= next_col;
    end
  end
endmodule : phy_basic_control_lower_bits

//--- verification/ctl_checker.sv
// port assertions for the lower control bits
// bound into every instance of the block, one clock domain
`timescale 1ns/1ps
module ctl_checker import phy_ctrl_pkg::*; (
  input wire logic clk, rst_n, clkEn, regWrite, power_down_input_pin_n,
  input wire logic duplexStrap, anEnable, anStarted, anFullDuplex, txEn,
  input wire logic portPowerDown, portIsolate, anRestartReq, fullDuplex, col,
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [REG_DATA_W-1:0] regWriteData, regReadData
);
  localparam int onMax = 512;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence started;
    anStarted && !regWrite && clkEn ##1 clkEn && !regWrite &&
      regAddr == 5'h00;
  endsequence
  sequence fresh;
    $past(rst_n) && $past(clkEn) && $past(regAddr) == 5'h00;
  endsequence
  a_reserved_zero: assert property (regReadData[6:0] == 7'h00)
    else $error("reserved bits not zero");
  a_col_rise: assert property ((clkEn && txEn && regAddr == 5'h00 &&
    regReadData[7] && regReadData[11:10] == 2'h0 && !portPowerDown)[*2]
    |-> ##[0:onMax] col) else $error("col late");
  a_col_fall: assert property ($fell(txEn) |-> ##[1:4] !col)
    else $error("col stuck");
  a_pin_down: assert property ((!power_down_input_pin_n && clkEn)[*7]
    |-> portPowerDown) else $error("pin ignored");
  a_iso_follow: assert property (fresh |-> portIsolate == regReadData[10])
    else $error("isolate wrong");
  a_restart_gate: assert property (anRestartReq |-> $past(anEnable))
    else $error("restart not gated");
  a_restart_req: assert property (anRestartReq && $past(regAddr) == 5'h00
    && $past(clkEn) |-> regReadData[9]) else $error("req bit");
  a_self_clear: assert property (started |=> !regReadData[9])
    else $error("restart bit kept");
  a_duplex_pick: assert property (fresh |-> fullDuplex ==
    ($past(anEnable) ? $past(anFullDuplex) : regReadData[8]))
    else $error("duplex wrong");
endmodule : ctl_checker
bind phy_basic_control_lower_bits ctl_checker chk_u (.*);

//--- verification/an_engine_model.sv
// negotiation engine seen from the block, answers a restart request
// a slow engine: start is reported only after lag+1 cycles of request
`timescale 1ns/1ps
module an_engine_model (
  input wire logic clk,
  input wire logic req,
  input wire logic [3:0] lag,
  output logic started
);
  logic [3:0] cnt = 4'h0;
  initial started = 1'b0;
  always @(posedge clk) begin
    cnt <= req ? cnt + 4'h1 : 4'h0;
    started <= req && cnt == lag;
  end
endmodule : an_engine_model

//--- verification/phy_basic_control_lower_bits_bench.sv
// bench for the lower control bits, engine model on the far side
// strap tied to full duplex, clock enable held high
`timescale 1ns/1ps
module phy_basic_control_lower_bits_bench;
  import phy_ctrl_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, pinN = 1'b1;
  logic anEnable = 1'b0, anFullDuplex = 1'b1, txEn = 1'b0;
  logic anStarted, portPowerDown, portIsolate, anRestartReq, fullDuplex, col;
  logic [REG_ADDR_W-1:0] regAddr = 5'h00;
  logic [REG_DATA_W-1:0] regWriteData = 16'h0000, regReadData;
  int failCount = 0, testsRun = 0;
  always #5 clk = ~clk;
  phy_basic_control_lower_bits dut_u (.clk(clk), .rst_n(rst_n),
    .clkEn(1'b1), .regAddr(regAddr), .regWrite(regWrite),
    .regWriteData(regWriteData), .regReadData(regReadData),
    .power_down_input_pin_n(pinN), .duplexStrap(1'b1), .anEnable(anEnable),
    .anStarted(anStarted), .anFullDuplex(anFullDuplex), .txEn(txEn),
    .portPowerDown(portPowerDown), .portIsolate(portIsolate),
    .anRestartReq(anRestartReq), .fullDuplex(fullDuplex), .col(col));
  an_engine_model eng_u (.clk(clk), .req(anRestartReq), .lag(4'h3),
    .started(anStarted));
  task chk(input string what, input logic [15:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task endSim;
    $display("checks %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : endSim
  // readback lands one edge after the write edge
  task wr(input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regWriteData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
    #1;
  endtask : wr
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task testFields;
    chk("reset word", regReadData, 16'h0100);
    wr(16'hffff);
    chk("all ones", regReadData, 16'h0d80);
    chk("isolate", 16'(portIsolate), 16'h0001);
    chk("power down", 16'(portPowerDown), 16'h0001);
    wr(16'h0080);
    chk("half duplex", 16'(fullDuplex), 16'h0000);
    txEn <= 1'b1;
    tick(3);
    chk("col on", 16'(col), 16'h0001);
    txEn <= 1'b0;
    tick(4);
    chk("col off", 16'(col), 16'h0000);
    $display("fields done");
  endtask : testFields
  task testRestart;
    int i;
    anEnable <= 1'b1;
    wr(16'h0200);
    chk("restart req", 16'(anRestartReq), 16'h0001);
    wr(16'h0000);
    chk("pending", regReadData, 16'h0200);
    chk("an duplex", 16'(fullDuplex), 16'h0001);
    for (i = 0; i < 20 && anStarted !== 1'b1; i++)
      tick(1);
    if (anStarted !== 1'b1) begin
      failCount++;
      endSim();
    end
    tick(2);
    chk("self clear", regReadData, 16'h0000);
    $display("restart done");
  endtask : testRestart
  task testPin;
    pinN <= 1'b0;
    tick(8);
    chk("pin down", 16'(portPowerDown), 16'h0001);
    chk("pin reads", regReadData, 16'h0800);
    pinN <= 1'b1;
    tick(5);
    wr(16'h0000);
    chk("power up", 16'(portPowerDown), 16'h0000);
    regAddr <= 5'h01;
    tick(2);
    chk("unmapped", regReadData, 16'h0000);
    $display("pin done");
  endtask : testPin
  initial begin
    tick(8);
    rst_n <= 1'b1;
    tick(6);
    testFields();
    testRestart();
    testPin();
    endSim();
  end
endmodule : phy_basic_control_lower_bits_bench
